// ---- serial_pkg.sv ----
// Purpose: Shared constants for the serial baud, break and wake-up block
// Assumes: 8-bit register port, word-indexed register offsets
// Notes:   Offsets are local choices; field positions follow the register layouts
package serial_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] ADDR_STATUS   = 3'h0;
    localparam logic [2:0] ADDR_DATA     = 3'h1;
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h2;
    localparam logic [2:0] ADDR_CTRL_TWO = 3'h3;
    localparam logic [2:0] ADDR_BAUD     = 3'h4;
    localparam logic [2:0] ADDR_EXT_TX   = 3'h5;
    localparam logic [2:0] ADDR_EXT_RX   = 3'h6;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int STAT_TXE     = 7;
    localparam int STAT_TXDONE  = 6;
    localparam int STAT_RXRDY   = 5;
    localparam int STAT_IDLE    = 4;
    localparam int C1_NINTH_RX  = 7;
    localparam int C1_NINTH_TX  = 6;
    localparam int C1_WORD9     = 4;
    localparam int C1_WAKE_ADDR = 3;
    localparam int C2_TXE_IE    = 7;
    localparam int C2_TXDONE_IE = 6;
    localparam int C2_RXRDY_IE  = 5;
    localparam int C2_IDLE_IE   = 4;
    localparam int C2_TX_EN     = 3;
    localparam int C2_RX_EN     = 2;
    localparam int C2_MUTE      = 1;
    localparam int C2_BREAK     = 0;
    localparam int BAUD_COARSE  = 6;
    localparam int BAUD_TX      = 3;
    localparam int BAUD_RX      = 0;

    // ************************************************************
    // Reset values and timing
    // ************************************************************
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int         OVERSAMPLE = 16;

endpackage : serial_pkg

// ---- serial_baud_break_wakeup.sv ----
// Purpose: Serial transmitter with break, dual baud generators, mute/wake receiver
// Assumes: rx_i asynchronous to clk_i; 8-bit register port
// Notes:   Receiver samples mid-bit on the 16x tick of its own generator
//
// Functional notes
// - Send-break loads break frame of word length
// - Break frames repeat while send-break set
// - Conventional rate: clock over 16*coarse*range
// - Transmit range factor power of two
// - Receive range factor power of two
// - Extended mode divides 16x output further
// - Extended divider only when value nonzero
// - Extended rate adds extended factor per direction
// - Extended divider inactive after reset
// - Muted receiver sets no flags, no interrupts
// - Address-mark wake reports its frame; idle-line wake reports nothing
// - Empty flag set on shift load, interrupts
// - Empty cleared by status then data write
// - Done flag on data frame end, cleared
// - Idle and break frames never set done
// - Ready flag on receive, cleared by read
// - Word length 8 or 9, ninth bit separate
// - Transmit enable sends one idle frame first
`timescale 1ns/1ps

module serial_baud_break_wakeup (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       rx_i,
    output logic            tx_o,
    output logic            irq_o
);

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_t;
    typedef enum logic [1:0] {FR_DATA, FR_IDLE, FR_BREAK} frame_kind_t;

    // ************************************************************
    // Registers and state
    // ************************************************************
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [7:0]  baud_rate_reg;
    logic [7:0]  ext_tx_divider;
    logic [7:0]  ext_rx_divider;
    logic [7:0]  tx_holding_buffer;
    logic        tx_holding_ninth;
    logic        holding_full;
    logic [8:0]  rx_holding_buffer;
    logic        tx_holding_empty;
    logic        tx_done_flag;
    logic        rx_ready_flag;
    logic        idle_flag;
    logic        status_seen;
    tx_state_t   tx_state;
    frame_kind_t frame_kind;
    logic [10:0] tx_shift;
    logic [3:0]  tx_bits_left;
    logic [3:0]  tx_sub;
    logic        idle_pending;
    logic        tx_en_d;

    // Decoded controls
    logic       word9;
    logic       send_break_bit;
    logic       transmit_enable_bit;
    logic       receiver_mute;
    logic [3:0] frame_bits;
    assign word9               = ctrl_one[serial_pkg::C1_WORD9];
    assign send_break_bit      = ctrl_two[serial_pkg::C2_BREAK];
    assign transmit_enable_bit = ctrl_two[serial_pkg::C2_TX_EN];
    assign receiver_mute       = ctrl_two[serial_pkg::C2_MUTE];
    assign frame_bits          = word9 ? 4'hB : 4'hA;

    // ************************************************************
    // Baud generators
    // ************************************************************
    // Coarse factor decode
    function automatic logic [3:0] coarse_of(input logic [1:0] sel);
        case (sel)
            2'h0:    coarse_of = 4'h1;
            2'h1:    coarse_of = 4'h3;
            2'h2:    coarse_of = 4'h4;
            default: coarse_of = 4'hD;
        endcase
    endfunction : coarse_of

    // Total prescale before 16x tick: coarse * range * extended
    function automatic logic [18:0] period_of(input logic [1:0] cs,
                                             input logic [2:0] rs,
                                             input logic [7:0] ext);
        logic [18:0] base;
        base = 19'({coarse_of(cs), 7'h00} >> (3'h7 - rs));
        if (ext != 8'h00) begin
            period_of = 19'(base * ext);
        end else begin
            period_of = base;
        end
    endfunction : period_of

    logic [18:0] tx_period;
    logic [18:0] rx_period;
    logic [18:0] tx_cnt;
    logic [18:0] rx_cnt;
    logic        tx_tick;
    logic        rx_tick;
    assign tx_period = period_of(baud_rate_reg[7:6], baud_rate_reg[5:3], ext_tx_divider);
    assign rx_period = period_of(baud_rate_reg[7:6], baud_rate_reg[2:0], ext_rx_divider);
    assign tx_tick   = (tx_cnt >= tx_period - 19'h1);
    assign rx_tick   = (rx_cnt >= rx_period - 19'h1);

    // Free-running counters; a shrunk period wraps at once, never a short pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_cnt <= 19'h0;
            rx_cnt <= 19'h0;
        end else begin
            tx_cnt <= tx_tick ? 19'h0 : tx_cnt + 19'h1;
            rx_cnt <= rx_tick ? 19'h0 : rx_cnt + 19'h1;
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    logic write_data;
    logic read_data;
    assign write_data = wr_i && addr_i == serial_pkg::ADDR_DATA;
    assign read_data  = rd_i && addr_i == serial_pkg::ADDR_DATA;

    // Control registers; extended dividers reset to zero so they start bypassed
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_one       <= serial_pkg::RESET_BYTE;
            ctrl_two       <= serial_pkg::RESET_BYTE;
            baud_rate_reg  <= serial_pkg::RESET_BYTE;
            ext_tx_divider <= serial_pkg::RESET_BYTE;
            ext_rx_divider <= serial_pkg::RESET_BYTE;
        end else if (wr_i) begin
            case (addr_i)
                serial_pkg::ADDR_CTRL_ONE: ctrl_one       <= wdata_i;
                serial_pkg::ADDR_CTRL_TWO: ctrl_two       <= wdata_i;
                serial_pkg::ADDR_BAUD:     baud_rate_reg  <= wdata_i;
                serial_pkg::ADDR_EXT_TX:   ext_tx_divider <= wdata_i;
                serial_pkg::ADDR_EXT_RX:   ext_rx_divider <= wdata_i;
                default: ;
            endcase
        end
    end

    // Status read arms the clear sequence; the next data access disarms it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_seen <= 1'b0;
        end else if (rd_i && addr_i == serial_pkg::ADDR_STATUS) begin
            status_seen <= 1'b1;
        end else if (write_data || read_data) begin
            status_seen <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                serial_pkg::ADDR_STATUS:   rdata_o <= {tx_holding_empty, tx_done_flag,
                                                       rx_ready_flag, idle_flag, 4'h0};
                serial_pkg::ADDR_DATA:     rdata_o <= rx_holding_buffer[7:0];
                serial_pkg::ADDR_CTRL_ONE: rdata_o <= {rx_holding_buffer[8], ctrl_one[6:0]};
                serial_pkg::ADDR_CTRL_TWO: rdata_o <= ctrl_two;
                serial_pkg::ADDR_BAUD:     rdata_o <= baud_rate_reg;
                serial_pkg::ADDR_EXT_TX:   rdata_o <= ext_tx_divider;
                serial_pkg::ADDR_EXT_RX:   rdata_o <= ext_rx_divider;
                default:                   rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

    // ************************************************************
    // Transmitter
    // ************************************************************
    logic tx_bit_end;
    logic frame_end;
    logic start_frame;
    logic idle_due;
    assign tx_bit_end  = tx_tick && tx_sub == 4'hF;
    assign frame_end   = tx_state == TX_SHIFT && tx_bit_end && tx_bits_left == 4'h1;
    assign start_frame = transmit_enable_bit && (tx_state == TX_IDLE || frame_end);
    assign idle_due    = idle_pending || (transmit_enable_bit && !tx_en_d);

    // Holding buffer: data write fills it and clears the empty flag
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_holding_buffer <= 8'h00;
            tx_holding_ninth  <= 1'b0;
            holding_full      <= 1'b0;
        end else if (write_data && status_seen) begin
            tx_holding_buffer <= wdata_i;
            tx_holding_ninth  <= ctrl_one[serial_pkg::C1_NINTH_TX];
            holding_full      <= 1'b1;
        end else if (start_frame && !idle_due && !send_break_bit) begin
            holding_full      <= 1'b0;
        end
    end

    // Frame sequencing: idle preamble first, break while requested, then data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state     <= TX_IDLE;
            frame_kind   <= FR_DATA;
            tx_shift     <= 11'h7FF;
            tx_bits_left <= 4'h0;
            tx_sub       <= 4'h0;
            idle_pending <= 1'b0;
            tx_en_d      <= 1'b0;
        end else begin
            tx_en_d <= transmit_enable_bit;
            if (transmit_enable_bit && !tx_en_d) begin
                idle_pending <= 1'b1;
            end
            if (tx_tick) begin
                tx_sub <= tx_sub + 4'h1;
            end
            case (tx_state)
                TX_IDLE: begin
                    tx_shift <= 11'h7FF;
                end
                TX_SHIFT: begin
                    if (tx_bit_end) begin
                        tx_shift     <= {1'b1, tx_shift[10:1]};
                        tx_bits_left <= tx_bits_left - 4'h1;
                        if (tx_bits_left == 4'h1) begin
                            tx_state <= TX_IDLE;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
            if (start_frame && (idle_due || send_break_bit || holding_full)) begin
                tx_state     <= TX_SHIFT;
                tx_bits_left <= frame_bits;
                tx_sub       <= 4'h0;
                if (idle_due) begin
                    idle_pending <= 1'b0;
                    frame_kind   <= FR_IDLE;
                    tx_shift     <= 11'h7FF;
                end else if (send_break_bit) begin
                    frame_kind   <= FR_BREAK;
                    tx_shift     <= 11'h000;
                end else begin
                    frame_kind   <= FR_DATA;
                    tx_shift     <= word9 ? {1'b1, tx_holding_ninth, tx_holding_buffer, 1'b0}
                                          : {2'h3, tx_holding_buffer, 1'b0};
                end
            end
        end
    end

    // Line idles high; break frames hold it low including the stop slot
    assign tx_o = tx_state == TX_SHIFT ? tx_shift[0] : 1'b1;

    // Empty and done flags; hardware set wins over the software clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_holding_empty <= 1'b1;
            tx_done_flag     <= 1'b1;
        end else begin
            if (start_frame && holding_full && !idle_due && !send_break_bit) begin
                tx_holding_empty <= 1'b1;
            end else if (write_data && status_seen) begin
                tx_holding_empty <= 1'b0;
            end
            if (frame_end && frame_kind == FR_DATA) begin
                tx_done_flag <= 1'b1;
            end else if (write_data && status_seen) begin
                tx_done_flag <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Receiver
    // ************************************************************
    logic        rx_meta;
    logic        rx_sync;
    logic        rx_busy;
    logic [3:0]  rx_sub;
    logic [3:0]  rx_bit_idx;
    logic [8:0]  rx_shift;
    logic [3:0]  idle_run;
    logic        rx_done;
    logic        mute_clear;
    logic        addr_mark;

    // Two-stage synchroniser on the serial input
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_i;
            rx_sync <= rx_meta;
        end
    end

    assign rx_done   = rx_busy && rx_tick && rx_sub == 4'h7 && rx_bit_idx == frame_bits - 4'h1;
    assign addr_mark = word9 ? rx_shift[8] : rx_shift[7];

    // Frame capture, sampling at mid-bit; idle counts a full frame of ones
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_busy    <= 1'b0;
            rx_sub     <= 4'h0;
            rx_bit_idx <= 4'h0;
            rx_shift   <= 9'h000;
            idle_run   <= 4'h0;
        end else if (!ctrl_two[serial_pkg::C2_RX_EN]) begin
            rx_busy  <= 1'b0;
            idle_run <= 4'h0;
        end else if (rx_tick) begin
            rx_sub <= rx_sub + 4'h1;
            if (!rx_busy && !rx_sync) begin
                rx_busy    <= 1'b1;
                rx_sub     <= 4'h1;
                rx_bit_idx <= 4'h0;
                idle_run   <= 4'h0;
            end else if (rx_busy && rx_sub == 4'h7) begin
                rx_bit_idx <= rx_bit_idx + 4'h1;
                if (rx_bit_idx != 4'h0 && rx_bit_idx < frame_bits - 4'h1) begin
                    rx_shift <= word9 ? {rx_sync, rx_shift[8:1]} : {1'b0, rx_sync, rx_shift[7:1]};
                end
                if (rx_done) begin
                    rx_busy <= 1'b0;
                end
            end else if (!rx_busy && rx_sub == 4'hF && idle_run != frame_bits) begin
                idle_run <= idle_run + 4'h1;
            end
        end
    end

    // Wake source: idle line or address mark in the received word
    assign mute_clear = ctrl_one[serial_pkg::C1_WAKE_ADDR] ? (rx_done && addr_mark)
                      : (!rx_busy && idle_run == frame_bits - 4'h1 && rx_tick && rx_sub == 4'hF);

    // Mute bit is a software bit; address-mark wake-up is reported by gating flags, not clearing it
    logic muted;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            muted <= 1'b0;
        end else if (!receiver_mute) begin
            muted <= 1'b0;
        end else if (!muted && !mute_clear) begin
            muted <= 1'b1;
        end else if (mute_clear) begin
            muted <= 1'b0;
        end
    end

    // Ready and idle flags, suppressed while muted; set wins over clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_holding_buffer <= 9'h000;
            rx_ready_flag     <= 1'b0;
            idle_flag         <= 1'b0;
        end else begin
            if (rx_done && !(muted && !mute_clear)) begin
                rx_holding_buffer <= rx_shift;
                rx_ready_flag     <= 1'b1;
            end else if (read_data && status_seen) begin
                rx_ready_flag     <= 1'b0;
            end
            if (!muted && !rx_busy && idle_run == frame_bits - 4'h1 && rx_tick
                && rx_sub == 4'hF) begin
                idle_flag <= 1'b1;
            end else if (read_data && status_seen) begin
                idle_flag <= 1'b0;
            end
        end
    end

    // Combined interrupt from the enabled flags
    assign irq_o = (tx_holding_empty && ctrl_two[serial_pkg::C2_TXE_IE])
                 || (tx_done_flag    && ctrl_two[serial_pkg::C2_TXDONE_IE])
                 || (rx_ready_flag   && ctrl_two[serial_pkg::C2_RXRDY_IE])
                 || (idle_flag       && ctrl_two[serial_pkg::C2_IDLE_IE]);

endmodule : serial_baud_break_wakeup

// ---- serial_baud_break_wakeup_properties.sv ----
// Purpose: Port-level assertions for the serial block
// Assumes: Dividers change only while disabled
// Notes:   Shadows writes to know the bit time
`timescale 1ns/1ps

module serial_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic       rx_i,
    input wire logic       tx_o,
    input wire logic       irq_o
);
    logic [7:0] ctrl_two;
    logic [7:0] cfg [4:6];
    int         low_run;
    int         bit_clks;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ************************************************************
    // Helper logic
    // ************************************************************
    // Shadow of control and divider writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_two <= serial_pkg::RESET_BYTE;
            cfg      <= '{default: serial_pkg::RESET_BYTE};
        end else if (wr_i && addr_i == serial_pkg::ADDR_CTRL_TWO) begin
            ctrl_two <= wdata_i;
        end else if (wr_i && addr_i >= serial_pkg::ADDR_BAUD && addr_i != 3'h7) begin
            cfg[addr_i] <= wdata_i;
        end
    end

    // Low run length
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i || tx_o) begin
            low_run <= 0;
        end else begin
            low_run <= low_run + 1;
        end
    end

    // Transmit bit time in clocks
    always_comb begin
        case (cfg[4][7:6])
            2'h0:    bit_clks = 16;
            2'h1:    bit_clks = 48;
            2'h2:    bit_clks = 64;
            default: bit_clks = 208;
        endcase
        bit_clks = bit_clks << cfg[4][5:3];
        if (cfg[5] != 8'h00) begin
            bit_clks = bit_clks * cfg[5];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_read_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("rdata_o not zero");
    chk_unmapped_zero: assert property ($past(rd_i && addr_i == 3'h7) |-> rdata_o == 8'h00)
        else $error("unmapped read nonzero");
    chk_ext_readback: assert property (
        rd_i && addr_i == serial_pkg::ADDR_EXT_RX |=> rdata_o == cfg[6])
        else $error("ext_rx_divider readback wrong");
    chk_irq_needs_enable: assert property (irq_o |-> ctrl_two[7:4] != 4'h0)
        else $error("irq_o without enable");
    chk_low_run_bits: assert property ($rose(tx_o) |-> low_run % bit_clks == 0)
        else $error("tx_o low run not whole bits");
    chk_idle_first: assert property ($rose(ctrl_two[3]) |-> tx_o [*8])
        else $error("tx_o not idle after enable");
    chk_reset_release: assert property ($fell(rst_i) |-> tx_o && !irq_o)
        else $error("outputs busy after reset");
    chk_break_holds_low: assert property ($rose(tx_o) |-> !ctrl_two[0])
        else $error("tx_o rose during break");
endmodule : serial_checker

bind serial_baud_break_wakeup serial_checker serial_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o)
);

// ---- serial_remote.sv ----
// Purpose: Remote serial device on both lines
// Assumes: 8-bit words, start low, stop high, LSB first
// Notes:   Bit time set from outside
`timescale 1ns/1ps

module serial_remote (
    input  wire logic       clk_i,
    input  wire logic       line_i,
    output logic            line_o,
    output logic            frame_o,
    output logic      [8:0] word_o
);
    int tx_clks = 16;

    initial begin
        line_o  = 1'b1;
        frame_o = 1'b0;
        word_o  = 9'h000;
    end

    // Mid-bit decoder, stop bit kept
    always begin
        @(posedge clk_i);
        if (line_i === 1'b0) begin
            repeat (tx_clks / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
                repeat (tx_clks) @(posedge clk_i);
                word_o[i] <= line_i;
            end
            frame_o <= 1'b1;
            @(posedge clk_i);
            frame_o <= 1'b0;
            repeat (tx_clks / 2 - 2) @(posedge clk_i);
        end
    end

    // Send one frame
    task automatic send_word(input logic [8:0] w, input int clks);
        line_o <= 1'b0;
        repeat (clks) @(posedge clk_i);
        for (int i = 0; i < 9; i++) begin
            line_o <= w[i];
            repeat (clks) @(posedge clk_i);
        end
    endtask : send_word
endmodule : serial_remote

// ---- serial_baud_break_wakeup_tb.sv ----
// Purpose: Self-checking bench for the serial block
// Assumes: Reads answer one cycle later
// Notes:   Queued expectations, one watcher
`timescale 1ns/1ps

module serial_baud_break_wakeup_tb;
    logic        clk_i;
    logic        rst_i;
    logic [2:0]  addr_i;
    logic [7:0]  wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [7:0]  rdata_o;
    logic        rx_i;
    logic        tx_o;
    logic        irq_o;
    logic        frame;
    logic [8:0]  word;
    logic        rd_seen;
    logic [15:0] note;
    logic [31:0] seed;
    logic [15:0] exp_rd [$];
    logic [8:0]  exp_tx [$];
    int          errors;
    int          check_count;
    int          clks;
    int          coarse_clks [4] = '{16, 48, 64, 208};

    serial_baud_break_wakeup serial_baud_break_wakeup_inst (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .tx_o(tx_o), .irq_o(irq_o)
    );
    serial_remote serial_remote_inst (
        .clk_i(clk_i), .line_i(tx_o), .line_o(rx_i), .frame_o(frame), .word_o(word)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        if (errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic bus_write(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : bus_write

    // Masked compare
    task automatic bus_read(input logic [2:0] a, input logic [7:0] m, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_rd.push_back({m, v});
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask : bus_read

    // Status access, then data write
    task automatic send_data();
        seed = xorshift(seed);
        bus_read(serial_pkg::ADDR_STATUS, 8'h00, 8'h00);
        bus_write(serial_pkg::ADDR_DATA, seed[7:0]);
    endtask : send_data

    // Bounded frame wait
    task automatic wait_tx(input int n);
        for (int i = 0; i < 20000 && exp_tx.size() > n; i++) @(posedge clk_i);
        if (exp_tx.size() > n) begin
            errors++;
            tally_and_finish();
        end
    endtask : wait_tx

    // ************************************************************
    // Clock and sequence
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Read data stands one cycle
    always @(posedge clk_i) begin
        if (rd_seen && exp_rd.size() > 0) begin
            note = exp_rd.pop_front();
            if (note[15:8] != 8'h00) check("rdata_o", {1'b0, note[7:0]}, {1'b0, rdata_o & note[15:8]});
        end
        rd_seen = rd_i;
        if (frame) check("tx_o frame", exp_tx.size() > 0 ? exp_tx.pop_front() : 9'hXXX, word);
    end

    initial begin
        rst_i = 1'b1; addr_i = 3'h0; wdata_i = 8'h00; wr_i = 1'b0; rd_i = 1'b0;
        rd_seen = 1'b0; seed = 32'h4780; errors = 0; check_count = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus_read(serial_pkg::ADDR_STATUS, 8'hE0, 8'hC0);
        bus_read(serial_pkg::ADDR_EXT_RX, 8'hFF, 8'h00);
        bus_read(3'h7, 8'hFF, 8'h00);
        // All coarse codes
        for (int c = 0; c < 4; c++) begin
            clks = (coarse_clks[c] << c[0]) * (c == 1 ? 3 : 1);
            bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h00);
            bus_write(serial_pkg::ADDR_BAUD, {c[1:0], 2'b00, c[0], 3'h1});
            bus_write(serial_pkg::ADDR_EXT_TX, c == 1 ? 8'h03 : 8'h00);
            serial_remote_inst.tx_clks = clks;
            bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h08);
            send_data();
            exp_tx.push_back({1'b1, seed[7:0]});
            bus_read(serial_pkg::ADDR_STATUS, 8'h40, 8'h00);
            wait_tx(0);
            repeat (clks) @(posedge clk_i);
            bus_read(serial_pkg::ADDR_STATUS, 8'hC0, 8'hC0);
        end
        // Breaks before pending data
        bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h00);
        bus_write(serial_pkg::ADDR_BAUD, 8'h01);
        bus_write(serial_pkg::ADDR_EXT_TX, 8'h03);
        bus_write(serial_pkg::ADDR_EXT_RX, 8'h02);
        bus_read(serial_pkg::ADDR_EXT_RX, 8'hFF, 8'h02);
        serial_remote_inst.tx_clks = 48;
        exp_tx.push_back(9'h000);
        exp_tx.push_back(9'h000);
        send_data();
        bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h09);
        wait_tx(1);
        bus_read(serial_pkg::ADDR_STATUS, 8'h40, 8'h00);
        wait_tx(0);
        bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h08);
        exp_tx.push_back({1'b1, seed[7:0]});
        wait_tx(0);
        repeat (48) @(posedge clk_i);
        bus_read(serial_pkg::ADDR_STATUS, 8'h40, 8'h40);
        // Muted receiver, address wake
        bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h00);
        bus_write(serial_pkg::ADDR_CTRL_ONE, 8'h08);
        bus_write(serial_pkg::ADDR_CTRL_TWO, 8'h26);
        seed = xorshift(seed);
        serial_remote_inst.send_word({2'b10, seed[6:0]}, 64);
        check("irq_o", 9'h000, {8'h00, irq_o});
        bus_read(serial_pkg::ADDR_STATUS, 8'h30, 8'h00);
        serial_remote_inst.send_word({2'b11, seed[6:0]}, 64);
        check("irq_o", 9'h001, {8'h00, irq_o});
        bus_read(serial_pkg::ADDR_STATUS, 8'h20, 8'h20);
        bus_read(serial_pkg::ADDR_DATA, 8'hFF, {1'b1, seed[6:0]});
        bus_read(serial_pkg::ADDR_STATUS, 8'h20, 8'h00);
        repeat (4) @(posedge clk_i);
        tally_and_finish();
    end
endmodule : serial_baud_break_wakeup_tb
